// *** rtl/dcr_defines.vh ***
// Constants for the datapath configuration register bank
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH

// ----------------------------------------------------------------
// Offsets and reset values
// ----------------------------------------------------------------
`define DCR_ADDR_W        7
`define DCR_OFS_DPCTL     7'h02
`define DCR_OFS_SCALE     7'h03
`define DCR_RST_DPCTL     16'h7000
`define DCR_RST_SCALE     16'hf000
`define DCR_RST_STEPS     5'h10
`define DCR_DPCTL_WMASK   16'hf0fa
`define DCR_SCALE_WMASK   16'hf001

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCR_B_WORD_WIDE   15
`define DCR_B_CCLK_ARM    14
`define DCR_B_DCLK_ARM    13
`define DCR_B_COLL_ARM    12
`define DCR_B_FOUR_WIRE   7
`define DCR_B_MIX_ENA     6
`define DCR_B_MIX_GAIN    5
`define DCR_B_OSC_ENA     4
`define DCR_B_REV_BUS     3
`define DCR_B_TWOS        1
`define DCR_F_STEP_HI     15
`define DCR_F_STEP_LO     12
`define DCR_B_SW_TXEN     0

// ----------------------------------------------------------------
// Alarm mask bits of the alarm mask register
// ----------------------------------------------------------------
`define DCR_M_COLL        13
`define DCR_M_CCLK        10
`define DCR_M_DCLK        9
`define DCR_M_MUTED       8

`define DCR_MID_SCALE     16'h8000

`endif

// *** rtl/dcr_regs.v ***
// Datapath control and output scale registers with derived controls
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defines.vh"

module dcr_regs #(
  parameter DATA_W = 16
) (
  // Clock and reset
  input  wire                   CLOCK_I,
  input  wire                   RESET_I,
  // Register write/read port from the serial configuration decoder
  input  wire                   WR_STB_I,
  input  wire [`DCR_ADDR_W-1:0] ADDR_I,
  input  wire [15:0]            WDATA_I,
  output reg  [15:0]            RDATA_O,
  // Alarm inputs and mask register contents
  input  wire                   CCLK_LOST_I,
  input  wire                   DCLK_LOST_I,
  input  wire                   COLLISION_I,
  input  wire [15:0]            ALARM_MASK_REG_I,
  // Transmit enable pin
  input  wire                   TXENABLE_PIN_I,
  // Input samples per channel
  input  wire [DATA_W-1:0]      SAMPLE_I_I,
  input  wire [DATA_W-1:0]      SAMPLE_Q_I,
  // Control outputs
  output reg                    WORD_WIDE_SEL_O,
  output reg                    FOUR_WIRE_PORT_SEL_O,
  output reg                    MIXER_ENA_O,
  output reg                    MIXER_GAIN_O,
  output reg                    OSC_ENA_O,
  output reg  [4:0]             FS_STEPS_O,
  output reg                    TX_ENABLE_O,
  output reg                    OUTPUT_MUTED_O,
  // Formatted samples toward the converter
  output reg  [DATA_W-1:0]      CONV_I_O,
  output reg  [DATA_W-1:0]      CONV_Q_O
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Register and step widths are fixed by the map; only the sample width varies
  localparam REG_W  = 16;
  localparam STEP_W = 5;
  localparam N_SRC  = 3;
  localparam N_CH   = 2;

  reg  [REG_W-1:0]       dpctl_r;
  reg  [REG_W-1:0]       dpctl_nxt;
  reg  [REG_W-1:0]       scale_r;
  reg  [REG_W-1:0]       scale_nxt;
  reg                    muted_r;
  wire                   mute_nxt;
  reg  [REG_W-1:0]       rdata_nxt;
  wire [STEP_W-1:0]      steps_nxt;
  wire                   tx_nxt;
  wire [N_CH*DATA_W-1:0] conv_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One decoder serves the write port and the read-back mux, so they never disagree
  function hits;
    input [`DCR_ADDR_W-1:0] addr;
    input [`DCR_ADDR_W-1:0] ofs;
    begin
      hits = (addr == ofs);
    end
  endfunction

  wire                   sel_dpctl;
  wire                   sel_scale;
  wire                   wr_dpctl;
  wire                   wr_scale;

  assign sel_dpctl = hits(ADDR_I, `DCR_OFS_DPCTL);
  assign sel_scale = hits(ADDR_I, `DCR_OFS_SCALE);
  assign wr_dpctl  = WR_STB_I & sel_dpctl;
  assign wr_scale  = WR_STB_I & sel_scale;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Reserved bits are held at zero whatever the host writes
  always @* begin
    dpctl_nxt = dpctl_r;
    if (wr_dpctl) begin
      dpctl_nxt = WDATA_I & `DCR_DPCTL_WMASK;
    end
  end

  always @* begin
    scale_nxt = scale_r;
    if (wr_scale) begin
      scale_nxt = WDATA_I & `DCR_SCALE_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Register flops
  // ----------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      dpctl_r <= `DCR_RST_DPCTL;
      scale_r <= `DCR_RST_SCALE;
    end else begin
      dpctl_r <= dpctl_nxt;
      scale_r <= scale_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Named fields
  // ----------------------------------------------------------------
  // Names for the bits that leave the block, so the output logic reads plainly
  wire                   f_word_wide;
  wire                   f_four_wire;
  wire                   f_mix_ena;
  wire                   f_mix_gain;
  wire                   f_osc_ena;
  wire                   f_rev_bus;
  wire                   f_twos;
  wire                   f_sw_txen;
  wire [3:0]             f_step;

  assign f_word_wide = dpctl_r[`DCR_B_WORD_WIDE];
  assign f_four_wire = dpctl_r[`DCR_B_FOUR_WIRE];
  assign f_mix_ena   = dpctl_r[`DCR_B_MIX_ENA];
  assign f_mix_gain  = dpctl_r[`DCR_B_MIX_GAIN];
  assign f_osc_ena   = dpctl_r[`DCR_B_OSC_ENA];
  assign f_rev_bus   = dpctl_r[`DCR_B_REV_BUS];
  assign f_twos      = dpctl_r[`DCR_B_TWOS];
  assign f_sw_txen   = scale_r[`DCR_B_SW_TXEN];
  assign f_step      = scale_r[`DCR_F_STEP_HI:`DCR_F_STEP_LO];

  // ----------------------------------------------------------------
  // Shutdown sources
  // ----------------------------------------------------------------
  // Index 0 is conversion clock loss, 1 input data clock loss, 2 pointer collision
  wire [N_SRC-1:0]       src_arm;
  wire [N_SRC-1:0]       src_alarm;
  wire [N_SRC-1:0]       src_unmasked;
  wire [N_SRC-1:0]       src_shut;
  wire                   muted_ok;

  assign src_arm      = {dpctl_r[`DCR_B_COLL_ARM],
                         dpctl_r[`DCR_B_DCLK_ARM],
                         dpctl_r[`DCR_B_CCLK_ARM]};
  assign src_alarm    = {COLLISION_I, DCLK_LOST_I, CCLK_LOST_I};
  assign src_unmasked = ~{ALARM_MASK_REG_I[`DCR_M_COLL],
                          ALARM_MASK_REG_I[`DCR_M_DCLK],
                          ALARM_MASK_REG_I[`DCR_M_CCLK]};
  assign muted_ok     = ~ALARM_MASK_REG_I[`DCR_M_MUTED];

  // Each source needs its arm bit, a raised alarm and its own flag unmasked
  genvar s;
  generate
    for (s = 0; s < N_SRC; s = s + 1) begin : g_src
      assign src_shut[s] = src_arm[s] & src_alarm[s] & src_unmasked[s];
    end
  endgenerate

  // A masked muted flag blocks every source, whatever the per-source masks say
  assign mute_nxt = muted_ok & (|src_shut);

  // ----------------------------------------------------------------
  // Mute state
  // ----------------------------------------------------------------
  // Not latched here: the alarm flags upstream hold the cause until the host clears them
  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      muted_r <= 1'b0;
    end else begin
      muted_r <= mute_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sample formatting
  // ----------------------------------------------------------------
  // Two's complement input reaches the converter as offset binary: flip the sign bit
  function [DATA_W-1:0] to_offset;
    input [DATA_W-1:0] d;
    input              twos;
    begin
      to_offset = twos ? {~d[DATA_W-1], d[DATA_W-2:0]} : d;
    end
  endfunction

  wire [N_CH*DATA_W-1:0] samp_all;

  assign samp_all = {SAMPLE_Q_I, SAMPLE_I_I};

  genvar c;
  genvar b;
  generate
    for (c = 0; c < N_CH; c = c + 1) begin : g_ch
      wire [DATA_W-1:0] raw;
      wire [DATA_W-1:0] flip;
      wire [DATA_W-1:0] ordered;
      wire [DATA_W-1:0] coded;

      assign raw = samp_all[c*DATA_W +: DATA_W];
      for (b = 0; b < DATA_W; b = b + 1) begin : g_bit
        assign flip[b] = raw[DATA_W-1-b];
      end
      assign ordered = f_rev_bus ? flip : raw;
      assign coded   = to_offset(ordered, f_twos);
      // Mid-scale keeps the converter at zero output while the alarm stands
      assign conv_nxt[c*DATA_W +: DATA_W] = muted_r ? `DCR_MID_SCALE : coded;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Unmapped indices read as zero, so a probe of the map sees no stale word
  always @* begin
    rdata_nxt = {REG_W{1'b0}};
    if (sel_dpctl) begin
      rdata_nxt = dpctl_r;
    end else if (sel_scale) begin
      rdata_nxt = scale_r;
    end
  end

  // Read data lags the index by one cycle
  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      RDATA_O <= {REG_W{1'b0}};
    end else begin
      RDATA_O <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Datapath controls
  // ----------------------------------------------------------------
  // Controls trail the register by one cycle; consumers see a clean flop edge
  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      WORD_WIDE_SEL_O      <= 1'b0;
      FOUR_WIRE_PORT_SEL_O <= 1'b0;
      MIXER_ENA_O          <= 1'b0;
      MIXER_GAIN_O         <= 1'b0;
      OSC_ENA_O            <= 1'b0;
    end else begin
      WORD_WIDE_SEL_O      <= f_word_wide;
      FOUR_WIRE_PORT_SEL_O <= f_four_wire;
      MIXER_ENA_O          <= f_mix_ena;
      MIXER_GAIN_O         <= f_mix_gain;
      // Coarse mixing needs only the mixer enable, not the oscillator
      OSC_ENA_O            <= f_osc_ena;
    end
  end

  // ----------------------------------------------------------------
  // Full-scale step count
  // ----------------------------------------------------------------
  // Reported as field plus one so a consumer can scale the current directly
  assign steps_nxt = {{(STEP_W-4){1'b0}}, f_step} + {{(STEP_W-1){1'b0}}, 1'b1};

  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      FS_STEPS_O <= `DCR_RST_STEPS;
    end else begin
      FS_STEPS_O <= steps_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transmit enable
  // ----------------------------------------------------------------
  // Either source turns the output on; both must be low to turn it off
  assign tx_nxt = f_sw_txen | TXENABLE_PIN_I;

  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      TX_ENABLE_O <= 1'b0;
    end else begin
      TX_ENABLE_O <= tx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------
  // Reset parks both paths at mid-scale so nothing is transmitted before setup
  always @(posedge CLOCK_I) begin
    if (RESET_I) begin
      OUTPUT_MUTED_O <= 1'b0;
      CONV_I_O       <= `DCR_MID_SCALE;
      CONV_Q_O       <= `DCR_MID_SCALE;
    end else begin
      OUTPUT_MUTED_O <= muted_r;
      CONV_I_O       <= conv_nxt[0 +: DATA_W];
      CONV_Q_O       <= conv_nxt[DATA_W +: DATA_W];
    end
  end

endmodule
`default_nettype wire

// *** verification/dcr_regs_sva.sv ***
// Checker for the datapath configuration register bank
`timescale 1ns/1ps
`default_nettype none
module dcr_regs_sva (
  input wire logic        CLOCK_I, RESET_I, WR_STB_I, TXENABLE_PIN_I, WORD_WIDE_SEL_O,
  input wire logic        FOUR_WIRE_PORT_SEL_O, MIXER_ENA_O, MIXER_GAIN_O, OSC_ENA_O,
  input wire logic        TX_ENABLE_O, OUTPUT_MUTED_O,
  input wire logic [6:0]  ADDR_I,
  input wire logic [4:0]  FS_STEPS_O,
  input wire logic [15:0] WDATA_I, RDATA_O, ALARM_MASK_REG_I, CONV_I_O, CONV_Q_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  // Controls trail a write by two edges: register, then output flop
  sequence s_dp; WR_STB_I && ADDR_I == 7'h02; endsequence
  sequence s_sc; WR_STB_I && ADDR_I == 7'h03; endsequence
  property p_ww; s_dp |-> ##2 WORD_WIDE_SEL_O == $past(WDATA_I[15], 2); endproperty
  a_ww: assert property (p_ww) else $error("word select wrong");
  property p_fw; s_dp |-> ##2 FOUR_WIRE_PORT_SEL_O == $past(WDATA_I[7], 2); endproperty
  a_fw: assert property (p_fw) else $error("port select wrong");
  property p_mx; s_dp |-> ##2 {MIXER_ENA_O, MIXER_GAIN_O, OSC_ENA_O} == $past(WDATA_I[6:4], 2);
  endproperty
  a_mx: assert property (p_mx) else $error("mixer controls wrong");
  property p_fs; s_sc |-> ##2 FS_STEPS_O == $past(WDATA_I[15:12], 2) + 5'h01; endproperty
  a_fs: assert property (p_fs) else $error("step count wrong");
  property p_tx; TXENABLE_PIN_I |=> TX_ENABLE_O; endproperty
  a_tx: assert property (p_tx) else $error("pin enable lost");
  property p_mk; ALARM_MASK_REG_I[8] |-> ##2 !OUTPUT_MUTED_O; endproperty
  a_mk: assert property (p_mk) else $error("masked mute");
  property p_mid; OUTPUT_MUTED_O |-> CONV_I_O == 16'h8000 && CONV_Q_O == 16'h8000; endproperty
  a_mid: assert property (p_mid) else $error("muted not mid-scale");
  property p_rs; ADDR_I == 7'h02 |=> (RDATA_O & 16'h0f05) == 16'h0000; endproperty
  a_rs: assert property (p_rs) else $error("reserved bits set");
endmodule
bind dcr_regs dcr_regs_sva u_sva (.*);
`default_nettype wire

// *** verification/dcr_host.sv ***
// Host model writing the configuration registers and alarm mask
`timescale 1ns/1ps
`default_nettype none
module dcr_host (
  input  wire logic        clk_i,
  output var  logic        stb_o, pin_o,
  output var  logic [6:0]  addr_o,
  output var  logic [15:0] wdata_o, mask_o
);
  initial {stb_o, pin_o, addr_o, wdata_o, mask_o} = {2'b00, 7'h02, 32'h0};
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1 stb_o = 1'b1;
    addr_o = a;
    wdata_o = d & (a == 7'h02 ? 16'hf0fa : 16'hf001);
    @(posedge clk_i);
    #1 stb_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/dcr_regs_test.sv ***
// Self-checking bench for the datapath configuration register bank
`timescale 1ns/1ps
`default_nettype none
module dcr_regs_test;
  logic        CLOCK_I = 1'b0, RESET_I = 1'b1, CCLK_LOST_I = 1'b0, DCLK_LOST_I = 1'b0;
  logic        COLLISION_I = 1'b0, mu_e;
  logic [15:0] SAMPLE_I_I = 16'h0000, SAMPLE_Q_I = 16'h0000, dp = 16'h7000, sc = 16'hf000;
  logic [6:0]  a;
  wire         WR_STB_I, TXENABLE_PIN_I, WORD_WIDE_SEL_O, FOUR_WIRE_PORT_SEL_O, MIXER_ENA_O;
  wire         MIXER_GAIN_O, OSC_ENA_O, TX_ENABLE_O, OUTPUT_MUTED_O;
  wire [6:0]   ADDR_I;
  wire [4:0]   FS_STEPS_O;
  wire [15:0]  WDATA_I, RDATA_O, ALARM_MASK_REG_I, CONV_I_O, CONV_Q_O;
  wire [11:0]  ctl = {WORD_WIDE_SEL_O, FOUR_WIRE_PORT_SEL_O, MIXER_ENA_O, MIXER_GAIN_O,
                      OSC_ENA_O, TX_ENABLE_O, OUTPUT_MUTED_O, FS_STEPS_O};
  int          n_mismatch = 0, check_count = 0;
  always #12.5 CLOCK_I = ~CLOCK_I;
  dcr_host h (.clk_i(CLOCK_I), .stb_o(WR_STB_I), .pin_o(TXENABLE_PIN_I), .addr_o(ADDR_I),
              .wdata_o(WDATA_I), .mask_o(ALARM_MASK_REG_I));
  dcr_regs DUT (.*);
  function automatic logic [15:0] fmt(input logic [15:0] s);
    logic [15:0] r;
    for (int k = 0; k < 16; k++) r[k] = dp[3] ? s[15-k] : s[k];
    return dp[1] ? r ^ 16'h8000 : r;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic look;
    logic [15:0] k;
    k = ~ALARM_MASK_REG_I;
    mu_e = k[8] & (dp[14] & CCLK_LOST_I & k[10] | dp[13] & DCLK_LOST_I & k[9]
                   | dp[12] & COLLISION_I & k[13]);
    chk("rdata", ADDR_I == 7'h02 ? dp : ADDR_I == 7'h03 ? sc : 16'h0000, RDATA_O);
    chk("ctl", 16'({dp[15], dp[7:4], sc[0] | TXENABLE_PIN_I, mu_e, sc[15:12] + 5'h01}),
        16'(ctl));
    chk("conv_i", mu_e ? 16'h8000 : fmt(SAMPLE_I_I), CONV_I_O);
    chk("conv_q", mu_e ? 16'h8000 : fmt(SAMPLE_Q_I), CONV_Q_O);
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatched %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(95));
    repeat (5) @(posedge CLOCK_I);
    #1 RESET_I = 1'b0;
    repeat (3) @(posedge CLOCK_I);
    #1 look;
    // Address 0x04 is unmapped, so writes there must leave both registers alone
    for (int i = 0; i < 80; i++) begin
      a = 7'(2 + $urandom % 3);
      h.wr(a, 16'($urandom));
      if (a == 7'h02) dp = WDATA_I & 16'hf0fa;
      if (a == 7'h03) sc = WDATA_I & 16'hf001;
      {CCLK_LOST_I, DCLK_LOST_I, COLLISION_I} = 3'($urandom);
      h.pin_o = 1'($urandom);
      h.mask_o = 16'($urandom) & 16'h2700;
      {SAMPLE_I_I, SAMPLE_Q_I} = $urandom;
      repeat (3) @(posedge CLOCK_I);
      #1 look;
    end
    h.wr(7'h03, 16'hf000);
    sc = 16'hf000;
    h.pin_o = 1'b0;
    repeat (3) @(posedge CLOCK_I);
    #1 look;
    finish_test;
  end
  initial begin
    #50us;
    n_mismatch++;
    finish_test;
  end
endmodule
`default_nettype wire
